// *** hdl/midi_router.sv ***
// Purpose: MIDI channel filter, input relay and clock master logic.
// Assumes: Inputs synchronous to mclk; one byte rx and tx serial.
// Notes:   Channel value 0..15 means channel 1..16, 16 means off.
//
// Function
// - After reset the synth and three rhythm tracks use channels 1 to 4.
// - Each track has its own channel setting 1 to 16 or off for rx.
// - A track set to off ignores every incoming channel message.
// - With relay on, every received byte goes unchanged to the output.
// - With relay off, the output carries the device's own messages.
// - As master, start/stop starts and then stops local and slave play.
// - With internal clock, timing clock messages are sent while play is on.
// - With external clock, received clock and start/stop are followed.
`timescale 1ns/10ps
`include "midi_router_defs.svh"

module midi_router (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       midi_in,
  output logic            midi_out,
  input  wire logic       start_stop_press,
  output logic            play_q,
  output logic            clock_tick_q,
  output logic            msg_valid_q,
  output logic      [1:0] msg_track_q,
  output logic      [7:0] msg_status_q
);

  // ****************************************************************
  // Register port
  // ****************************************************************
  logic [7:0] ctrl_q;
  logic [4:0] wr_chan;
  logic [19:0] chans;
  logic [7:0] rx_byte_q;
  logic [7:0] tx_hold_q;
  logic       tx_pend_q;
  logic       relay_on;
  logic       clk_ext;
  logic       wr_track;
  logic       wr_ctrl;
  logic       wr_tx;
  logic [7:0] rd_mux;

  assign relay_on = ctrl_q[`CTRL_RELAY_BIT];
  assign clk_ext  = ctrl_q[`CTRL_CLKSRC_BIT];
  assign wr_track = reg_wr && reg_addr[3:2] == 2'h0;
  assign wr_ctrl  = reg_wr && reg_addr == `ADDR_CONTROL;
  assign wr_tx    = reg_wr && reg_addr == `ADDR_TX_DATA;
  // Values above sixteen fold to off, whatever the upper bits hold.
  assign wr_chan  = (reg_wdata > {3'h0, `CHAN_OFF}) ? `CHAN_OFF
                                                     : reg_wdata[4:0];

  // The memory's own read port lags a cycle, so reads use the live copy
  // to keep the answer in the cycle right after the strobe.
  track_chan_mem u_mem (
    .mclk    (mclk),
    .rst     (rst),
    .wr_en   (wr_track),
    .wr_idx  (reg_addr[1:0]),
    .wr_val  (wr_chan),
    .rd_idx  (reg_addr[1:0]),
    .rd_val  (),
    .all_val (chans)
  );

  assign rd_mux =
    (reg_addr[3:2] == 2'h0)      ? {3'h0, chans[reg_addr[1:0]*5 +: 5]} :
    (reg_addr == `ADDR_CONTROL)  ? {ctrl_q[7:3], play_q, ctrl_q[1:0]} :
    (reg_addr == `ADDR_STATUS)   ? {6'h00, tx_pend_q, play_q} :
    (reg_addr == `ADDR_TX_DATA)  ? tx_hold_q :
    (reg_addr == `ADDR_RX_DATA)  ? rx_byte_q : 8'h00;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
      ctrl_q    <= `CTRL_RESET;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 8'h00;
      if (wr_ctrl) begin
        ctrl_q <= {reg_wdata[7:3], 1'b0, reg_wdata[1:0]};
      end
    end
  end

  // ****************************************************************
  // Serial receiver
  // ****************************************************************
  midi_router_pkg::ser_state_type rx_st_q;
  logic [10:0] rx_cnt_q;
  logic [2:0]  rx_bit_q;
  logic [7:0]  rx_sh_q;
  logic        rx_done_q;
  logic        rx_mid;

  assign rx_mid = rx_cnt_q == 11'(`BIT_CYCLES - 1);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rx_st_q   <= midi_router_pkg::SER_IDLE;
      rx_cnt_q  <= 11'h000;
      rx_bit_q  <= 3'h0;
      rx_sh_q   <= 8'h00;
      rx_done_q <= 1'b0;
      rx_byte_q <= 8'h00;
    end else begin
      rx_done_q <= 1'b0;
      rx_cnt_q  <= rx_mid ? 11'h000 : rx_cnt_q + 11'h001;
      case (rx_st_q)
        midi_router_pkg::SER_IDLE: begin
          rx_cnt_q <= 11'(`BIT_CYCLES / 2);
          if (!midi_in) begin
            rx_st_q <= midi_router_pkg::SER_START;
          end
        end
        midi_router_pkg::SER_START: begin
          if (rx_mid) begin
            rx_st_q  <= midi_in ? midi_router_pkg::SER_IDLE
                                : midi_router_pkg::SER_DATA;
            rx_bit_q <= 3'h0;
          end
        end
        midi_router_pkg::SER_DATA: begin
          if (rx_mid) begin
            rx_sh_q  <= {midi_in, rx_sh_q[7:1]};
            rx_bit_q <= rx_bit_q + 3'h1;
            if (rx_bit_q == 3'h7) begin
              rx_st_q <= midi_router_pkg::SER_STOP;
            end
          end
        end
        midi_router_pkg::SER_STOP: begin
          if (rx_mid) begin
            rx_st_q   <= midi_router_pkg::SER_IDLE;
            rx_done_q <= midi_in;
            rx_byte_q <= rx_sh_q;
          end
        end
        default: rx_st_q <= midi_router_pkg::SER_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Channel filter and realtime follow
  // ****************************************************************
  logic [7:0] run_status_q;
  logic       tick_q;
  logic [3:0] hit;
  logic [1:0] hit_idx;
  logic       is_status;
  logic       is_chan;

  assign is_status = rx_byte_q[7];
  assign is_chan   = is_status && rx_byte_q[7:4] != 4'hf;

  genvar t;
  generate
    for (t = 0; t < 4; t++) begin : gen_hit
      // An off setting can never equal a four bit channel.
      assign hit[t] = chans[t*5 +: 5] == {1'b0, rx_byte_q[3:0]};
    end
  endgenerate

  assign hit_idx = hit[0] ? 2'd0 : hit[1] ? 2'd1 : hit[2] ? 2'd2 : 2'd3;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      run_status_q <= 8'h00;
      msg_valid_q  <= 1'b0;
      msg_track_q  <= 2'h0;
      msg_status_q <= 8'h00;
      clock_tick_q <= 1'b0;
      play_q       <= 1'b0;
    end else begin
      msg_valid_q  <= 1'b0;
      clock_tick_q <= 1'b0;
      if (rx_done_q && is_chan) begin
        run_status_q <= rx_byte_q;
        // Unmatched messages die here; the relay path is independent.
        if (|hit) begin
          msg_valid_q  <= 1'b1;
          msg_track_q  <= hit_idx;
          msg_status_q <= rx_byte_q;
        end
      end
      if (clk_ext) begin
        if (rx_done_q && rx_byte_q == 8'hf8) clock_tick_q <= 1'b1;
        if (rx_done_q && (rx_byte_q == 8'hfa || rx_byte_q == 8'hfb)) begin
          play_q <= 1'b1;
        end
        if (rx_done_q && rx_byte_q == 8'hfc) play_q <= 1'b0;
      end else begin
        if (tick_q) clock_tick_q <= 1'b1;
        if (start_stop_press) play_q <= !play_q;
      end
    end
  end

  // ****************************************************************
  // Transmit: clock, start/stop and software bytes
  // ****************************************************************
  logic [15:0] tick_cnt_q;
  logic        start_req_q;
  logic        stop_req_q;
  logic        clk_req_q;
  logic [9:0]  tx_sh_q;
  logic [3:0]  tx_bits_q;
  logic [10:0] tx_cnt_q;
  logic        tx_line_q;
  logic        tx_idle;

  assign tx_idle = tx_bits_q == 4'h0;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tick_cnt_q  <= 16'h0000;
      tick_q      <= 1'b0;
      start_req_q <= 1'b0;
      stop_req_q  <= 1'b0;
      clk_req_q   <= 1'b0;
      tx_hold_q   <= 8'h00;
      tx_pend_q   <= 1'b0;
      tx_sh_q     <= 10'h3ff;
      tx_bits_q   <= 4'h0;
      tx_cnt_q    <= 11'h000;
      tx_line_q   <= 1'b1;
    end else begin
      tick_q     <= 1'b0;
      tick_cnt_q <= tick_cnt_q + 16'h0001;
      if (tick_cnt_q == 16'(`TICK_CYCLES - 1) || !play_q) begin
        tick_cnt_q <= 16'h0000;
        tick_q     <= play_q && !clk_ext;
      end
      if (wr_tx && !tx_pend_q) begin
        tx_hold_q <= reg_wdata;
        tx_pend_q <= 1'b1;
      end
      if (tx_idle) begin
        // Realtime bytes first, so clock jitter stays low.
        if (clk_req_q) begin
          tx_sh_q   <= {1'b1, 8'hf8, 1'b0};
          clk_req_q <= 1'b0;
          tx_bits_q <= 4'ha;
        end else if (start_req_q) begin
          tx_sh_q     <= {1'b1, 8'hfa, 1'b0};
          start_req_q <= 1'b0;
          tx_bits_q   <= 4'ha;
        end else if (stop_req_q) begin
          tx_sh_q    <= {1'b1, 8'hfc, 1'b0};
          stop_req_q <= 1'b0;
          tx_bits_q  <= 4'ha;
        end else if (tx_pend_q) begin
          tx_sh_q   <= {1'b1, tx_hold_q, 1'b0};
          tx_pend_q <= 1'b0;
          tx_bits_q <= 4'ha;
        end
        tx_cnt_q <= 11'h000;
      end else if (tx_cnt_q == 11'(`BIT_CYCLES - 1)) begin
        tx_cnt_q  <= 11'h000;
        // Each wrap puts the next bit up for a full bit time.
        tx_line_q <= tx_sh_q[1];
        tx_sh_q   <= {1'b1, tx_sh_q[9:1]};
        tx_bits_q <= tx_bits_q - 4'h1;
      end else begin
        tx_cnt_q <= tx_cnt_q + 11'h001;
        if (tx_cnt_q == 11'h000 && tx_bits_q == 4'ha) tx_line_q <= tx_sh_q[0];
      end
      // Set after the load above, so a request arriving as the previous
      // one is taken is never lost.
      if (tick_q) clk_req_q <= 1'b1;
      // The slave's start and stop ride on the same press.
      if (!clk_ext && start_stop_press) begin
        if (play_q) stop_req_q <= 1'b1;
        else start_req_q <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Output selection
  // ****************************************************************
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      midi_out <= 1'b1;
    end else if (relay_on) begin
      midi_out <= midi_in;
    end else begin
      midi_out <= tx_line_q;
    end
  end

endmodule : midi_router

// *** hdl/midi_router_defs.svh ***
// Purpose: Constants for the MIDI channel and relay router.
// Assumes: 40 MHz clock, serial link at 31250 baud.
// Notes:   Included by the router and its track memory.
`ifndef MIDI_ROUTER_DEFS_SVH
`define MIDI_ROUTER_DEFS_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define ADDR_TRACK0      4'h0
`define ADDR_TRACK1      4'h1
`define ADDR_TRACK2      4'h2
`define ADDR_TRACK3      4'h3
`define ADDR_CONTROL     4'h4
`define ADDR_STATUS      4'h5
`define ADDR_TX_DATA     4'h6
`define ADDR_RX_DATA     4'h7

// ****************************************************************
// Fields and reset values
// ****************************************************************
`define CHAN_OFF         5'h10
`define CTRL_RELAY_BIT   0
`define CTRL_CLKSRC_BIT  1
`define CTRL_STARTSTOP   2
`define CTRL_RESET       8'h00

// ****************************************************************
// Timing
// ****************************************************************
`define CLK_HZ           40000000
`define BAUD_HZ          31250
`define BIT_CYCLES       (`CLK_HZ / `BAUD_HZ)
`define TICK_HZ          2400
`define TICK_CYCLES      (`CLK_HZ / `TICK_HZ)

`endif

// *** hdl/midi_router_pkg.sv ***
// Purpose: Types for the MIDI channel and relay router.
// Assumes: Nothing beyond the constants header.
// Notes:   Used by name, never imported.
package midi_router_pkg;

  typedef enum logic [1:0] {
    SER_IDLE  = 2'b00,
    SER_START = 2'b01,
    SER_DATA  = 2'b11,
    SER_STOP  = 2'b10
  } ser_state_type;

endpackage : midi_router_pkg

// *** hdl/track_chan_mem.sv ***
// Purpose: Per-track channel settings with registered read port.
// Assumes: Four tracks, five bit settings.
// Notes:   Reset loads channels one to four.
`timescale 1ns/10ps
`include "midi_router_defs.svh"

module track_chan_mem (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       wr_en,
  input  wire logic [1:0] wr_idx,
  input  wire logic [4:0] wr_val,
  input  wire logic [1:0] rd_idx,
  output logic      [4:0] rd_val,
  output logic      [19:0] all_val
);

  logic [4:0] chan_q [4];

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : gen_trk
      always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
          chan_q[g] <= 5'(g);
        end else if (wr_en && wr_idx == 2'(g)) begin
          chan_q[g] <= wr_val;
        end
      end
      assign all_val[g*5 +: 5] = chan_q[g];
    end
  endgenerate

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rd_val <= 5'h00;
    end else begin
      rd_val <= chan_q[rd_idx];
    end
  end

endmodule : track_chan_mem

// *** dv/midi_router_chk.sv ***
// Purpose: Port checker for the MIDI router.
// Assumes: One clock, rst asynchronous and active high.
// Notes:   Shadows control and track writes to predict the outputs.
`timescale 1ns/10ps
module midi_router_chk (
  input wire logic       mclk,
  input wire logic       rst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       midi_in,
  input wire logic       midi_out,
  input wire logic       start_stop_press,
  input wire logic       play_q,
  input wire logic       clock_tick_q,
  input wire logic       msg_valid_q,
  input wire logic [1:0] msg_track_q,
  input wire logic [7:0] msg_status_q
);
  // ****************************************************************
  // Shadow state
  // ****************************************************************
  logic       rly_q;
  logic       ext_q;
  logic [4:0] ch_q [4];
  wire  [4:0] w_ch = (reg_wdata > 8'h10) ? 5'h10 : reg_wdata[4:0];
  wire  [4:0] w_rd = ch_q[reg_addr[1:0]];

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rly_q <= 1'b0;
      ext_q <= 1'b0;
      for (int i = 0; i < 4; i++) ch_q[i] <= 5'(i);
    end else if (reg_wr && reg_addr == 4'h4) begin
      rly_q <= reg_wdata[0];
      ext_q <= reg_wdata[1];
    end else if (reg_wr && reg_addr < 4'h4) begin
      ch_q[reg_addr[1:0]] <= w_ch;
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  // ****************************************************************
  // Assertions
  // ****************************************************************
  relay_copy_a: assert property (
    $past(rly_q) |-> midi_out == $past(midi_in))
    else $error("relayed output differs from input");
  chan_match_a: assert property (
    msg_valid_q |-> ch_q[msg_track_q] == {1'b0, msg_status_q[3:0]})
    else $error("reported track does not own that channel");
  status_kind_a: assert property (
    msg_valid_q |-> msg_status_q[7] && msg_status_q[7:4] != 4'hf)
    else $error("non channel byte reported");
  msg_pulse_a: assert property (msg_valid_q |=> !msg_valid_q)
    else $error("message strobe longer than one cycle");
  track_read_a: assert property (
    $past(reg_rd) && $past(reg_addr) < 4'h4 |-> reg_rdata == $past(w_rd))
    else $error("track setting read back wrong");
  unmapped_rd_a: assert property (
    $past(reg_rd) && $past(reg_addr) >= 4'h8 |-> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  play_start_a: assert property (
    !ext_q && start_stop_press && !play_q |=> play_q)
    else $error("press did not start playback");
  play_stop_a: assert property (
    !ext_q && start_stop_press && play_q |=> !play_q)
    else $error("press did not stop playback");
  ext_hold_a: assert property (
    ext_q && start_stop_press |=> $stable(play_q))
    else $error("press acted under external clock");
  tick_pulse_a: assert property (clock_tick_q |=> !clock_tick_q)
    else $error("tick strobe longer than one cycle");

  cover property (msg_valid_q);
  cover property ($rose(play_q));
  cover property (clock_tick_q && ext_q);
endmodule : midi_router_chk

bind midi_router midi_router_chk u_chk (
  .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .midi_in(midi_in), .midi_out(midi_out),
  .start_stop_press(start_stop_press), .play_q(play_q),
  .clock_tick_q(clock_tick_q), .msg_valid_q(msg_valid_q),
  .msg_track_q(msg_track_q), .msg_status_q(msg_status_q));

// *** dv/midi_kbd_model.sv ***
// Purpose: Keyboard or sequencer on the far end of the serial link.
// Assumes: 8N1 framing, least significant bit first, idle high.
// Notes:   Sends on request and collects every byte it receives.
`timescale 1ns/10ps
`include "midi_router_defs.svh"
module midi_kbd_model (
  input  wire logic mclk,
  input  wire logic from_dev,
  output logic      to_dev
);
  logic [7:0] rx_q [$];

  initial to_dev = 1'b1;

  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    @(posedge mclk);
    for (int i = 0; i < 10; i++) begin
      to_dev <= f[i];
      repeat (`BIT_CYCLES) @(posedge mclk);
    end
  endtask : send_byte

  // As slave it takes start, stop and clock bytes as they come.
  initial begin : rx_loop
    logic [7:0] b;
    forever begin
      @(posedge mclk);
      if (from_dev === 1'b0) begin
        repeat (`BIT_CYCLES / 2) @(posedge mclk);
        for (int i = 0; i < 8; i++) begin
          repeat (`BIT_CYCLES) @(posedge mclk);
          b[i] = from_dev;
        end
        repeat (`BIT_CYCLES) @(posedge mclk);
        rx_q.push_back(b);
      end
    end
  end
endmodule : midi_kbd_model

// *** dv/midi_router_test.sv ***
// Purpose: Self-checking bench for the MIDI router.
// Assumes: 40 MHz mclk, keyboard model on the serial link.
// Notes:   Frames are long, so the run spends most time on the wire.
`timescale 1ns/10ps
module midi_router_test;
  logic       mclk = 1'b0;
  logic       rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic       press = 1'b0;
  logic [7:0] reg_rdata, msg_status_q, last_s, b;
  logic [1:0] msg_track_q, last_t;
  logic       midi_in, midi_out, play_q, clock_tick_q, msg_valid_q;
  int         error_cnt = 0;
  int         n_checks = 0;
  int         v_cnt = 0;
  int         t_cnt = 0;

  always #12.5 mclk = ~mclk;

  midi_router u_dut (
    .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .midi_in(midi_in), .midi_out(midi_out), .start_stop_press(press),
    .play_q(play_q), .clock_tick_q(clock_tick_q),
    .msg_valid_q(msg_valid_q), .msg_track_q(msg_track_q),
    .msg_status_q(msg_status_q));
  midi_kbd_model u_kbd (.mclk(mclk), .from_dev(midi_out), .to_dev(midi_in));

  always @(posedge mclk) begin
    if (msg_valid_q === 1'b1) begin
      v_cnt++;
      last_t = msg_track_q;
      last_s = msg_status_q;
    end
    if (clock_tick_q === 1'b1) t_cnt++;
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask : rd

  task automatic pr(input logic e);
    @(posedge mclk);
    press <= 1'b1;
    @(posedge mclk);
    press <= 1'b0;
    repeat (2) @(posedge mclk);
    #1 chk({7'h00, play_q}, {7'h00, e});
  endtask : pr

  // A byte that never arrives comes back unknown and fails its compare.
  task automatic get(output logic [7:0] v);
    int n;
    n = 0;
    while (u_kbd.rx_q.size() == 0 && n < 30000) begin
      @(posedge mclk);
      n++;
    end
    v = (u_kbd.rx_q.size() > 0) ? u_kbd.rx_q.pop_front() : 8'hxx;
  endtask : get

  task automatic snd(input logic [7:0] m, input int n,
                     input logic [1:0] t, input logic [7:0] s);
    logic [7:0] r;
    u_kbd.send_byte(m);
    repeat (40) @(posedge mclk);
    chk(8'(v_cnt), 8'(n));
    chk({6'h00, last_t}, {6'h00, t});
    chk(last_s, s);
    get(r);
    chk(r, m);
    rd(4'h7, m);
  endtask : snd

  task automatic test_done;
    $display("checks=%0d errors=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : test_done

  // ****************************************************************
  // Sequence
  // ****************************************************************
  initial begin
    repeat (120000) @(posedge mclk);
    error_cnt++;
    test_done();
  end

  initial begin
    int n;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    for (int i = 0; i < 4; i++) rd(4'(i), 8'(i));
    rd(4'h4, 8'h00);
    wr(4'h9, 8'hff);
    rd(4'h9, 8'h00);
    wr(4'h1, 8'h13);
    rd(4'h1, 8'h10);
    wr(4'h1, 8'h05);
    rd(4'h1, 8'h05);
    wr(4'h4, 8'h01);
    snd(8'h90, 1, 2'h0, 8'h90);
    snd(8'h95, 2, 2'h1, 8'h95);
    wr(4'h0, 8'h10);
    snd(8'h90, 2, 2'h1, 8'h95);
    // The device's own bytes only reach the keyboard with relay off, so stale bytes go first.
    wr(4'h4, 8'h00);
    u_kbd.rx_q.delete();
    pr(1'b1);
    get(b);
    chk(b, 8'hfa);
    get(b);
    chk(b, 8'hf8);
    pr(1'b0);
    for (int i = 0; i < 4 && b == 8'hf8; i++) get(b);
    chk(b, 8'hfc);
    wr(4'h4, 8'h02);
    pr(1'b0);
    wr(4'h6, 8'h3c);
    u_kbd.send_byte(8'hfa);
    repeat (40) @(posedge mclk);
    chk({7'h00, play_q}, 8'h01);
    rd(4'h5, 8'h01);
    get(b);
    chk(b, 8'h3c);
    n = t_cnt;
    u_kbd.send_byte(8'hf8);
    repeat (40) @(posedge mclk);
    chk(8'(t_cnt - n), 8'h01);
    test_done();
  end
endmodule : midi_router_test
